//--- usc_defines.svh
// Register indices, field positions, reset values and timing counts of the USART control block
`ifndef USC_DEFINES_SVH
`define USC_DEFINES_SVH

`define USC_IDX_TX_RX_DATA 10'h0b8
`define USC_IDX_BAUD_DIV 10'h0b9
`define USC_IDX_UART_CTRL_STATUS 10'h0ba
`define USC_IDX_RX_CTRL_STATUS 10'h0bb
`define USC_IDX_IRQ_CLOCK_CTRL 10'h0bc

`define USC_PARITY_ENABLE 7
`define USC_PARITY_SEL_HI 6
`define USC_TX_NINTH_BIT 5
`define USC_FRAME_LEN_HI 4
`define USC_FRAME_LEN_LO 3
`define USC_ERROR_SUMMARY 2
`define USC_RX_FULL 1
`define USC_TX_EMPTY 0

`define USC_OVERRUN 7
`define USC_FRAMING 6
`define USC_PARITY_FAULT 5
`define USC_LINE_BREAK 4
`define USC_RX_NINTH 3
`define USC_ADDR_WAIT 2
`define USC_TX_ACTIVE 1
`define USC_RX_FAULT_HOLD 0

`define USC_TWO_STOP 7
`define USC_FORCE_BREAK 6
`define USC_TX_PIN_EN 5
`define USC_SYNC_MODE 4
`define USC_RX_EXT_CLK 3
`define USC_TX_EXT_CLK 2
`define USC_RX_IRQ_EN 1
`define USC_TX_IRQ_EN 0

`define USC_CTRL_RST 8'h00
`define USC_TX_EMPTY_RST 1'b1
`define USC_DIV_RST 11'h000
`define USC_SUB_LAST 4'hf
`define USC_START_CHECK 4'h7
// Loaded at the start check so that the next vote ends on the sixteenth tick
`define USC_CENTRE 4'ha
`define USC_VOTE_FIRST 4'h7
`define USC_VOTE_LAST 4'h9
`define USC_RESP_OKAY 2'b00
`define USC_RESP_DECERR 2'b11

`endif

//--- usc_pkg.sv
// Types of the USART control block: bus and pin carriers, states, register state
package usc_pkg;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } usc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } usc_axi_rsp_t;

  typedef struct packed {
    logic serial_in_pin;
    logic shift_clock_in;
    logic tx_port_is_output;
    logic clock_port_is_output;
  } usc_pins_in_t;

  typedef struct packed {
    logic serial_out_pin;
    logic serial_out_oe_n;
    logic shift_clock_out;
    logic shift_clock_oe_n;
    logic rx_irq;
    logic tx_irq;
  } usc_pins_out_t;

  typedef enum logic [2:0] {USC_TX_IDLE, USC_TX_START, USC_TX_DATA, USC_TX_PAR, USC_TX_STOP}
    usc_tx_st_t;
  typedef enum logic [2:0] {USC_RX_IDLE, USC_RX_START, USC_RX_DATA, USC_RX_PAR, USC_RX_STOP}
    usc_rx_st_t;

  typedef struct packed {
    logic [7:0] uart_ctrl;
    logic [7:0] irq_clock_ctrl;
    logic [7:0] tx_holding;
    logic [7:0] rx_holding;
    logic [10:0] divisor;
    logic rx_full;
    logic tx_empty;
    logic overrun;
    logic framing;
    logic parity_fault;
    logic line_break;
    logic rx_ninth;
    logic addr_wait;
    logic tx_active;
    logic rx_fault_hold;
    logic [10:0] div_cnt;
    logic bclk;
    logic ckx_prev;
    usc_tx_st_t tx_st;
    logic [8:0] tx_shifter;
    logic [3:0] tx_cnt;
    logic [3:0] tx_sub;
    logic tx_par;
    logic tx_line;
    logic tx_stop2nd;
    logic txd;
    usc_rx_st_t rx_st;
    logic [8:0] rx_shifter;
    logic [3:0] rx_cnt;
    logic [3:0] rx_sub;
    logic [1:0] rx_votes;
    logic rx_par;
    logic rx_perr;
    logic rx_zero;
    logic aw_got;
    logic [11:0] awaddr;
    logic w_got;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } usc_state_t;

endpackage : usc_pkg

//--- usc_usart_ctrl.sv
// USART control, status, framing and pin logic behind an AXI4-Lite register slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`include "usc_defines.svh"

// Function
// - Parity only when enabled, 7/8-bit frames
// - Parity kind: odd, even, mark, space
// - Shared bit: ninth bit or parity select
// - Frame length bits give 8, 7, 9
// - Both length bits: loopback, nine-bit framing
// - Summary error bit, read-only, reset clear
// - Receive full set on load, read clears
// - Transmit empty set on load, write clears
// - Sticky error flags cleared by status read
// - Line break flag held until status read
// - Received ninth bit stored read-only
// - Attention mode cleared on ninth bit
// - Transmitting flag drops after last stop
// - Fault hold until receive line high
// - Stop select: one or two stops
// - Break control holds transmit pin low
// - Transmit pin needs enable and output
// - Mode select: async or sync
// - Receiver clock internal or clock pin
// - Transmitter clock internal or clock pin
// - Separate receive and transmit interrupt enables
// - Clock pin outputs internal baud clock
// - Async sixteen ticks per bit, sync one
// - Async start confirmed mid-bit, three-sample vote
// - Interrupts pending while flag and enable
// - Receiver needs only one stop bit
module usc_usart_ctrl
  import usc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire usc_axi_req_t axi_req,
  output usc_axi_rsp_t axi_rsp,
  input wire usc_pins_in_t pins_in,
  output usc_pins_out_t pins_out
);

  usc_state_t s_r;
  usc_state_t s_nxt;

  logic nine;
  logic loopback;
  logic par_on;
  logic sync_mode;
  logic [3:0] ndata;
  logic par_seed;
  logic div_wrap;
  logic int_rise;
  logic int_fall;
  logic ext_rise;
  logic ext_fall;
  logic tx_tick;
  logic rx_tick;
  logic tx_bit_end;
  logic tx_load;
  logic tx_par_bit;
  logic rx_in;
  logic rx_dec;
  logic rx_bit;
  logic [1:0] vote_sum;
  logic [7:0] rx_data;
  logic rx_data_ninth;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic [9:0] rd_idx;
  logic [9:0] wr_idx;
  logic data_read;
  logic status_read;
  logic data_write;

  always_comb begin
    s_nxt = s_r;
    nine = s_r.uart_ctrl[`USC_FRAME_LEN_HI];
    loopback = s_r.uart_ctrl[`USC_FRAME_LEN_HI] & s_r.uart_ctrl[`USC_FRAME_LEN_LO];
    ndata = nine ? 4'd9 : (s_r.uart_ctrl[`USC_FRAME_LEN_LO] ? 4'd7 : 4'd8);
    par_on = s_r.uart_ctrl[`USC_PARITY_ENABLE] & ~nine;
    // Odd parity starts the running xor at one, even at zero
    par_seed = ~s_r.uart_ctrl[`USC_TX_NINTH_BIT];
    sync_mode = s_r.irq_clock_ctrl[`USC_SYNC_MODE];

    // Baud clock: square wave toggling every divisor+1 cycles
    div_wrap = (s_r.div_cnt == s_r.divisor);
    s_nxt.div_cnt = div_wrap ? 11'h000 : s_r.div_cnt + 11'h001;
    s_nxt.bclk = div_wrap ? ~s_r.bclk : s_r.bclk;
    int_rise = div_wrap & ~s_r.bclk;
    int_fall = div_wrap & s_r.bclk;
    s_nxt.ckx_prev = pins_in.shift_clock_in;
    ext_rise = pins_in.shift_clock_in & ~s_r.ckx_prev;
    ext_fall = ~pins_in.shift_clock_in & s_r.ckx_prev;
    // Sync mode: send on rising edge, sample on falling edge
    tx_tick = s_r.irq_clock_ctrl[`USC_TX_EXT_CLK] ? ext_rise : int_rise;
    if (s_r.irq_clock_ctrl[`USC_RX_EXT_CLK]) begin
      rx_tick = sync_mode ? ext_fall : ext_rise;
    end else begin
      rx_tick = sync_mode ? int_fall : int_rise;
    end

    // Bus handshakes
    aw_hs = axi_req.awvalid & ~s_r.aw_got & ~s_r.bvalid;
    w_hs = axi_req.wvalid & ~s_r.w_got & ~s_r.bvalid;
    ar_hs = axi_req.arvalid & ~s_r.rvalid;
    rd_idx = axi_req.araddr[11:2];
    wr_idx = s_r.awaddr[11:2];
    data_read = ar_hs & (rd_idx == `USC_IDX_TX_RX_DATA);
    status_read = ar_hs & (rd_idx == `USC_IDX_RX_CTRL_STATUS);
    data_write = s_r.aw_got & s_r.w_got & s_r.wstrb[0] & (wr_idx == `USC_IDX_TX_RX_DATA);

    if (aw_hs) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = axi_req.awaddr;
    end
    if (w_hs) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = axi_req.wdata[15:0];
      s_nxt.wstrb = axi_req.wstrb[1:0];
    end
    if (s_r.bvalid & axi_req.bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_got & s_r.w_got) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `USC_RESP_OKAY;
      case (wr_idx)
        `USC_IDX_UART_CTRL_STATUS: begin
          // Status bits 2:0 are hardware owned
          if (s_r.wstrb[0]) begin
            s_nxt.uart_ctrl = {s_r.wdata[7:3], 3'b000};
          end
        end
        `USC_IDX_RX_CTRL_STATUS: begin
          if (s_r.wstrb[0]) begin
            s_nxt.addr_wait = s_r.wdata[`USC_ADDR_WAIT];
          end
        end
        `USC_IDX_IRQ_CLOCK_CTRL: begin
          if (s_r.wstrb[0]) begin
            s_nxt.irq_clock_ctrl = s_r.wdata[7:0];
          end
        end
        `USC_IDX_TX_RX_DATA: begin
          if (s_r.wstrb[0]) begin
            s_nxt.tx_holding = s_r.wdata[7:0];
          end
        end
        `USC_IDX_BAUD_DIV: begin
          if (s_r.wstrb[0]) begin
            s_nxt.divisor[7:0] = s_r.wdata[7:0];
          end
          if (s_r.wstrb[1]) begin
            s_nxt.divisor[10:8] = s_r.wdata[10:8];
          end
        end
        default: begin
          s_nxt.bresp = `USC_RESP_DECERR;
        end
      endcase
    end

    if (s_r.rvalid & axi_req.rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (ar_hs) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `USC_RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      case (rd_idx)
        `USC_IDX_UART_CTRL_STATUS: begin
          s_nxt.rdata[7:3] = s_r.uart_ctrl[7:3];
          s_nxt.rdata[`USC_ERROR_SUMMARY] = s_r.overrun | s_r.framing | s_r.parity_fault |
                                            s_r.line_break;
          s_nxt.rdata[`USC_RX_FULL] = s_r.rx_full;
          s_nxt.rdata[`USC_TX_EMPTY] = s_r.tx_empty;
        end
        `USC_IDX_RX_CTRL_STATUS: begin
          s_nxt.rdata[7:0] = {s_r.overrun, s_r.framing, s_r.parity_fault, s_r.line_break,
                              s_r.rx_ninth, s_r.addr_wait, s_r.tx_active, s_r.rx_fault_hold};
        end
        `USC_IDX_IRQ_CLOCK_CTRL: begin
          s_nxt.rdata[7:0] = s_r.irq_clock_ctrl;
        end
        `USC_IDX_TX_RX_DATA: begin
          s_nxt.rdata[7:0] = s_r.rx_holding;
        end
        `USC_IDX_BAUD_DIV: begin
          s_nxt.rdata[10:0] = s_r.divisor;
        end
        default: begin
          s_nxt.rresp = `USC_RESP_DECERR;
        end
      endcase
    end
    // Read clears come first so that a same-cycle hardware set wins
    if (data_read) begin
      s_nxt.rx_full = 1'b0;
    end
    if (status_read) begin
      s_nxt.overrun = 1'b0;
      s_nxt.framing = 1'b0;
      s_nxt.parity_fault = 1'b0;
      s_nxt.line_break = 1'b0;
    end

    // Transmitter
    tx_bit_end = tx_tick & (sync_mode | (s_r.tx_sub == `USC_SUB_LAST));
    tx_load = 1'b0;
    if (tx_tick & ~sync_mode & (s_r.tx_st != USC_TX_IDLE)) begin
      s_nxt.tx_sub = s_r.tx_sub + 4'h1;
    end
    if (s_r.uart_ctrl[`USC_PARITY_SEL_HI]) begin
      tx_par_bit = ~s_r.uart_ctrl[`USC_TX_NINTH_BIT];
    end else begin
      tx_par_bit = s_r.tx_par;
    end
    case (s_r.tx_st)
      USC_TX_IDLE: begin
        s_nxt.tx_line = 1'b1;
        tx_load = tx_tick & ~s_r.tx_empty;
      end
      USC_TX_START: begin
        if (tx_bit_end) begin
          s_nxt.tx_st = USC_TX_DATA;
          s_nxt.tx_line = s_r.tx_shifter[0];
          s_nxt.tx_par = s_r.tx_par ^ s_r.tx_shifter[0];
          s_nxt.tx_shifter = {1'b0, s_r.tx_shifter[8:1]};
          s_nxt.tx_cnt = 4'h0;
        end
      end
      USC_TX_DATA: begin
        if (tx_bit_end) begin
          if (s_r.tx_cnt == ndata - 4'd1) begin
            s_nxt.tx_st = par_on ? USC_TX_PAR : USC_TX_STOP;
            s_nxt.tx_line = par_on ? tx_par_bit : 1'b1;
            s_nxt.tx_stop2nd = 1'b0;
          end else begin
            s_nxt.tx_line = s_r.tx_shifter[0];
            s_nxt.tx_par = s_r.tx_par ^ s_r.tx_shifter[0];
            s_nxt.tx_shifter = {1'b0, s_r.tx_shifter[8:1]};
            s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
          end
        end
      end
      USC_TX_PAR: begin
        if (tx_bit_end) begin
          s_nxt.tx_st = USC_TX_STOP;
          s_nxt.tx_line = 1'b1;
          s_nxt.tx_stop2nd = 1'b0;
        end
      end
      USC_TX_STOP: begin
        if (tx_bit_end) begin
          if (s_r.irq_clock_ctrl[`USC_TWO_STOP] & ~s_r.tx_stop2nd) begin
            s_nxt.tx_stop2nd = 1'b1;
          end else if (~s_r.tx_empty) begin
            tx_load = 1'b1;
          end else begin
            s_nxt.tx_st = USC_TX_IDLE;
            s_nxt.tx_active = 1'b0;
          end
        end
      end
      default: begin
        s_nxt.tx_st = USC_TX_IDLE;
      end
    endcase
    if (tx_load) begin
      s_nxt.tx_shifter = {s_r.uart_ctrl[`USC_TX_NINTH_BIT], s_r.tx_holding};
      s_nxt.tx_empty = 1'b1;
      s_nxt.tx_active = 1'b1;
      s_nxt.tx_st = USC_TX_START;
      s_nxt.tx_line = 1'b0;
      s_nxt.tx_sub = 4'h0;
      s_nxt.tx_par = par_seed;
    end
    // A holding write in the load cycle must keep the new byte pending
    if (data_write) begin
      s_nxt.tx_empty = 1'b0;
    end
    s_nxt.txd = s_r.irq_clock_ctrl[`USC_FORCE_BREAK] ? 1'b0 : s_nxt.tx_line;

    // Receiver
    rx_in = loopback ? s_r.txd : pins_in.serial_in_pin;
    vote_sum = s_r.rx_votes + {1'b0, rx_in};
    rx_dec = rx_tick & (sync_mode | (s_r.rx_sub == `USC_VOTE_LAST));
    rx_bit = sync_mode ? rx_in : vote_sum[1];
    if (nine) begin
      rx_data = s_r.rx_shifter[7:0];
    end else if (s_r.uart_ctrl[`USC_FRAME_LEN_LO]) begin
      rx_data = {1'b0, s_r.rx_shifter[8:2]};
    end else begin
      rx_data = s_r.rx_shifter[8:1];
    end
    rx_data_ninth = s_r.rx_shifter[8];
    if (rx_tick & ~sync_mode & (s_r.rx_st != USC_RX_IDLE)) begin
      s_nxt.rx_sub = s_r.rx_sub + 4'h1;
      if ((s_r.rx_sub >= `USC_VOTE_FIRST) & (s_r.rx_sub < `USC_VOTE_LAST)) begin
        s_nxt.rx_votes = vote_sum;
      end else begin
        s_nxt.rx_votes = 2'b00;
      end
    end
    case (s_r.rx_st)
      USC_RX_IDLE: begin
        if (rx_tick & ~rx_in) begin
          s_nxt.rx_st = sync_mode ? USC_RX_DATA : USC_RX_START;
          s_nxt.rx_sub = 4'h0;
          s_nxt.rx_cnt = 4'h0;
          s_nxt.rx_par = par_seed;
          s_nxt.rx_zero = 1'b1;
        end
      end
      USC_RX_START: begin
        // Recheck half a bit after the falling edge
        if (rx_tick & (s_r.rx_sub == `USC_START_CHECK)) begin
          s_nxt.rx_st = rx_in ? USC_RX_IDLE : USC_RX_DATA;
          s_nxt.rx_sub = `USC_CENTRE;
          s_nxt.rx_votes = 2'b00;
        end
      end
      USC_RX_DATA: begin
        if (rx_dec) begin
          s_nxt.rx_shifter = {rx_bit, s_r.rx_shifter[8:1]};
          s_nxt.rx_par = s_r.rx_par ^ rx_bit;
          s_nxt.rx_zero = s_r.rx_zero & ~rx_bit;
          if (s_r.rx_cnt == ndata - 4'd1) begin
            s_nxt.rx_st = par_on ? USC_RX_PAR : USC_RX_STOP;
            s_nxt.rx_perr = 1'b0;
          end else begin
            s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
          end
        end
      end
      USC_RX_PAR: begin
        if (rx_dec) begin
          s_nxt.rx_st = USC_RX_STOP;
          s_nxt.rx_zero = s_r.rx_zero & ~rx_bit;
          if (s_r.uart_ctrl[`USC_PARITY_SEL_HI]) begin
            s_nxt.rx_perr = rx_bit ^ ~s_r.uart_ctrl[`USC_TX_NINTH_BIT];
          end else begin
            s_nxt.rx_perr = s_r.rx_par ^ rx_bit;
          end
        end
      end
      USC_RX_STOP: begin
        // Only one stop bit is checked whatever the transmit setting
        if (rx_dec) begin
          s_nxt.rx_st = USC_RX_IDLE;
          if (~rx_bit & s_r.rx_zero) begin
            s_nxt.line_break = 1'b1;
            s_nxt.rx_fault_hold = 1'b1;
          end else if (~(s_r.addr_wait & nine & ~rx_data_ninth)) begin
            // Attention mode drops characters whose ninth bit is clear
            if (~rx_bit) begin
              s_nxt.framing = 1'b1;
              s_nxt.rx_fault_hold = 1'b1;
            end
            if (s_r.rx_perr & par_on) begin
              s_nxt.parity_fault = 1'b1;
            end
            if (s_r.rx_full & ~data_read) begin
              s_nxt.overrun = 1'b1;
            end else begin
              s_nxt.rx_holding = rx_data;
              s_nxt.rx_full = 1'b1;
              if (nine) begin
                s_nxt.rx_ninth = rx_data_ninth;
              end
            end
            if (nine & rx_data_ninth) begin
              s_nxt.addr_wait = 1'b0;
            end
          end
        end
      end
      default: begin
        s_nxt.rx_st = USC_RX_IDLE;
      end
    endcase
    if (rx_in & ~(s_nxt.rx_fault_hold & ~s_r.rx_fault_hold)) begin
      s_nxt.rx_fault_hold = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.uart_ctrl <= `USC_CTRL_RST;
      s_r.irq_clock_ctrl <= `USC_CTRL_RST;
      s_r.divisor <= `USC_DIV_RST;
      s_r.tx_empty <= `USC_TX_EMPTY_RST;
      s_r.tx_st <= USC_TX_IDLE;
      s_r.rx_st <= USC_RX_IDLE;
      s_r.tx_line <= 1'b1;
      s_r.txd <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    axi_rsp.awready = ~s_r.aw_got & ~s_r.bvalid;
    axi_rsp.wready = ~s_r.w_got & ~s_r.bvalid;
    axi_rsp.bvalid = s_r.bvalid;
    axi_rsp.bresp = s_r.bresp;
    axi_rsp.arready = ~s_r.rvalid;
    axi_rsp.rvalid = s_r.rvalid;
    axi_rsp.rdata = s_r.rdata;
    axi_rsp.rresp = s_r.rresp;
    pins_out.serial_out_pin = s_r.txd;
    pins_out.serial_out_oe_n = ~(s_r.irq_clock_ctrl[`USC_TX_PIN_EN] &
                                 pins_in.tx_port_is_output);
    pins_out.shift_clock_out = s_r.bclk;
    pins_out.shift_clock_oe_n = ~pins_in.clock_port_is_output;
    pins_out.rx_irq = s_r.rx_full & s_r.irq_clock_ctrl[`USC_RX_IRQ_EN];
    pins_out.tx_irq = s_r.tx_empty & s_r.irq_clock_ctrl[`USC_TX_IRQ_EN];
  end

endmodule : usc_usart_ctrl

//--- usc_usart_ctrl_monitor.sv
// Port-level assertions of the USART control block, bound to its top module
`timescale 1ns/100ps
module usc_usart_ctrl_monitor
  import usc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire usc_axi_req_t axi_req,
  input wire usc_axi_rsp_t axi_rsp,
  input wire usc_pins_in_t pins_in,
  input wire usc_pins_out_t pins_out
);
  logic [11:0] aw_r;
  logic [7:0] wd_r;
  logic ws_r;
  logic bv_r;
  logic [7:0] irq_r;
  logic wr_first;
  logic [7:0] irq_eff;

  // Shadow of the irq/clock register; new value counts from the bvalid cycle
  assign wr_first = axi_rsp.bvalid & ~bv_r;
  assign irq_eff = (wr_first && ws_r && aw_r == 12'h2f0) ? wd_r : irq_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 12'h000;
      wd_r <= 8'h00;
      ws_r <= 1'b0;
      bv_r <= 1'b0;
      irq_r <= 8'h00;
    end else begin
      bv_r <= axi_rsp.bvalid;
      irq_r <= irq_eff;
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_r <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        wd_r <= axi_req.wdata[7:0];
        ws_r <= axi_req.wstrb[0];
      end
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  pin_enable_a: assert property (
    pins_out.serial_out_oe_n == !(irq_eff[5] && pins_in.tx_port_is_output))
    else $error("transmit pin enable mismatch");
  clock_dir_a: assert property (
    pins_out.shift_clock_oe_n == !pins_in.clock_port_is_output)
    else $error("clock pin direction mismatch");
  break_low_a: assert property (
    irq_eff[6] && $past(irq_eff[6]) |-> !pins_out.serial_out_pin)
    else $error("transmit pin not low during break");
  start_len_a: assert property (
    $fell(pins_out.serial_out_pin) && !irq_eff[6] && !irq_eff[4]
    |-> !pins_out.serial_out_pin [*8])
    else $error("start bit too short");
  tx_irq_gate_a: assert property (
    pins_out.tx_irq |-> irq_eff[0])
    else $error("transmit interrupt while disabled");
  rx_irq_gate_a: assert property (
    pins_out.rx_irq |-> irq_eff[1])
    else $error("receive interrupt while disabled");
  tx_irq_hold_a: assert property (
    $fell(pins_out.tx_irq) && irq_eff[0] |-> wr_first && aw_r == 12'h2e0)
    else $error("transmit interrupt dropped without data write");
  rx_irq_hold_a: assert property (
    $fell(pins_out.rx_irq) && irq_eff[1]
    |-> $past(axi_req.arvalid && axi_rsp.arready && axi_req.araddr == 12'h2e0))
    else $error("receive interrupt dropped without data read");
endmodule : usc_usart_ctrl_monitor

bind usc_usart_ctrl usc_usart_ctrl_monitor mon (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .pins_in(pins_in), .pins_out(pins_out));

//--- usc_serial_peer.sv
// Remote serial transceiver model on the transmit, receive and clock pins
`timescale 1ns/100ps
module usc_serial_peer #(
  parameter int BIT_CYC = 32
) (
  input wire logic aclk,
  input wire logic serial_out_pin,
  output logic serial_in_pin,
  output logic shift_clock_in
);
  logic [10:0] got_bits;
  int got_cnt = 0;

  initial begin
    serial_in_pin = 1'b1;
    // Internal clocks only, so the pin clock stands still
    shift_clock_in = 1'b0;
  end

  task line(input logic v);
    @(posedge aclk);
    serial_in_pin <= v;
  endtask : line

  // Bad frames come only from the bits the bench hands in
  task send(input logic [10:0] bits, input int n, input logic last);
    line(1'b0);
    repeat (BIT_CYC) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      serial_in_pin <= bits[i];
      repeat (BIT_CYC) @(posedge aclk);
    end
    serial_in_pin <= last;
  endtask : send

  // Samples mid-bit; keeps the eleven bits that follow the start bit
  always begin
    @(negedge serial_out_pin);
    repeat (BIT_CYC / 2) @(posedge aclk);
    for (int i = 0; i < 11; i++) begin
      repeat (BIT_CYC) @(posedge aclk);
      got_bits[i] = serial_out_pin;
    end
    got_cnt++;
  end
endmodule : usc_serial_peer

//--- usc_usart_ctrl_tb_top.sv
// Self-checking testbench of the USART control block
`timescale 1ns/100ps
module usc_usart_ctrl_tb_top
  import usc_pkg::*;
();
  logic aclk = 1'b0;
  logic aresetn;
  usc_axi_req_t req;
  usc_axi_rsp_t rsp;
  usc_pins_in_t pin_i;
  usc_pins_out_t pin_o;
  logic sin;
  logic sck;
  logic tx_cfg;
  logic ck_cfg;
  int n_errors = 0;
  int num_checks = 0;
  logic [7:0] fc [7] = '{8'h00, 8'h88, 8'ha8, 8'hc8, 8'he8, 8'h30, 8'h08};
  logic [7:0] fd [7] = '{8'ha5, 8'h55, 8'h55, 8'h55, 8'h55, 8'h5a, 8'h55};
  logic [10:0] fe [7] = '{11'h7a5, 11'h7d5, 11'h755, 11'h7d5, 11'h755, 11'h75a, 11'h7d5};

  always #50 aclk = ~aclk;
  assign pin_i = {sin, sck, tx_cfg, ck_cfg};

  usc_usart_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .pins_in(pin_i), .pins_out(pin_o));
  usc_serial_peer peer (.aclk(aclk), .serial_out_pin(pin_o.serial_out_pin),
    .serial_in_pin(sin), .shift_clock_in(sck));

  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task stop_test;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w, b;
    int n;
    b = 1'b0;
    n = 0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h00_0000, d};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    while (!b && n < 100) begin
      @(negedge aclk);
      aw = req.awvalid & rsp.awready;
      w = req.wvalid & rsp.wready;
      b = rsp.bvalid;
      if (b) check(32'(rsp.bresp), 32'(er));
      @(posedge aclk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (b) req.bready <= 1'b0;
      n++;
    end
    if (!b) n_errors++;
  endtask : wr

  task rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e, input logic [1:0] er);
    logic ar, r;
    int n;
    r = 1'b0;
    n = 0;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (!r && n < 100) begin
      @(negedge aclk);
      ar = req.arvalid & rsp.arready;
      r = rsp.rvalid;
      if (r) check(rsp.rdata & {24'h00_0000, m}, {24'h00_0000, e});
      if (r) check(32'(rsp.rresp), 32'(er));
      @(posedge aclk);
      if (ar) req.arvalid <= 1'b0;
      if (r) req.rready <= 1'b0;
      n++;
    end
    if (!r) n_errors++;
  endtask : rd

  task wait_peer(input int k);
    for (int i = 0; i < 3000 && peer.got_cnt == k; i++) @(posedge aclk);
    if (peer.got_cnt == k) n_errors++;
  endtask : wait_peer

  task tx_frame(input logic [7:0] c, input logic [7:0] d, input logic [10:0] e);
    int k;
    k = peer.got_cnt;
    wr(12'h2e8, c, 2'b00);
    wr(12'h2e0, d, 2'b00);
    rd(12'h2ec, 8'h02, 8'h02, 2'b00);
    wait_peer(k);
    check(32'(peer.got_bits), 32'(e));
    rd(12'h2ec, 8'h02, 8'h00, 2'b00);
    rd(12'h2e8, 8'h01, 8'h01, 2'b00);
  endtask : tx_frame

  initial begin
    int k;
    aresetn = 1'b0;
    req = '0;
    tx_cfg = 1'b1;
    ck_cfg = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h2e8, 8'hff, 8'h01, 2'b00);
    rd(12'h2ec, 8'hff, 8'h00, 2'b00);
    rd(12'h2f0, 8'hff, 8'h00, 2'b00);
    rd(12'h3fc, 8'hff, 8'h00, 2'b11);
    wr(12'h3f8, 8'hff, 2'b11);
    wr(12'h2e8, 8'h07, 2'b00);
    rd(12'h2e8, 8'h07, 8'h01, 2'b00);
    wr(12'h2f0, 8'h23, 2'b00);
    ck_cfg <= 1'b1;
    @(negedge aclk);
    check(32'(pin_o.tx_irq), 32'h1);
    check(32'(pin_o.serial_out_oe_n), 32'h0);
    for (int i = 0; i < 7; i++) tx_frame(fc[i], fd[i], fe[i]);
    k = peer.got_cnt;
    wr(12'h2f0, 8'h63, 2'b00);
    @(negedge aclk);
    check(32'(pin_o.serial_out_pin), 32'h0);
    wr(12'h2f0, 8'h23, 2'b00);
    wait_peer(k);
    tx_frame(8'h18, 8'h5a, 11'h65a);
    rd(12'h2e0, 8'hff, 8'h5a, 2'b00);
    // Receive path, with overrun, framing and break faults
    wr(12'h2e8, 8'h00, 2'b00);
    peer.send({3'b111, 8'h3c}, 9, 1'b1);
    @(negedge aclk);
    check(32'(pin_o.rx_irq), 32'h1);
    rd(12'h2e0, 8'hff, 8'h3c, 2'b00);
    @(negedge aclk);
    check(32'(pin_o.rx_irq), 32'h0);
    peer.send({3'b111, 8'h11}, 9, 1'b1);
    peer.send({3'b111, 8'h22}, 9, 1'b1);
    rd(12'h2e8, 8'h04, 8'h04, 2'b00);
    rd(12'h2ec, 8'h80, 8'h80, 2'b00);
    rd(12'h2ec, 8'h80, 8'h00, 2'b00);
    rd(12'h2e8, 8'h04, 8'h00, 2'b00);
    rd(12'h2e0, 8'hff, 8'h11, 2'b00);
    peer.send({3'b110, 8'h0f}, 9, 1'b1);
    rd(12'h2ec, 8'h61, 8'h40, 2'b00);
    rd(12'h2e0, 8'hff, 8'h0f, 2'b00);
    peer.send(11'h000, 9, 1'b0);
    rd(12'h2ec, 8'h11, 8'h11, 2'b00);
    peer.line(1'b1);
    rd(12'h2ec, 8'h11, 8'h00, 2'b00);
    // Line still low after the break reads as a start; drain that all-ones char
    repeat (400) @(posedge aclk);
    rd(12'h2e0, 8'hff, 8'hff, 2'b00);
    wr(12'h2e8, 8'h10, 2'b00);
    wr(12'h2ec, 8'h04, 2'b00);
    rd(12'h2ec, 8'h04, 8'h04, 2'b00);
    peer.send({3'b010, 8'h21}, 10, 1'b1);
    rd(12'h2e8, 8'h02, 8'h00, 2'b00);
    peer.send({3'b011, 8'h42}, 10, 1'b1);
    rd(12'h2ec, 8'h0c, 8'h08, 2'b00);
    rd(12'h2e0, 8'hff, 8'h42, 2'b00);
    tx_cfg <= 1'b0;
    @(negedge aclk);
    check(32'(pin_o.serial_out_oe_n), 32'h1);
    stop_test;
  end

  // Tests take about 6300 cycles
  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    stop_test;
  end
endmodule : usc_usart_ctrl_tb_top
